// [sbc_pkg.sv]
// Package of constants and types for the status, configuration and interrupt registers
// ----------------------------------------------------------------------------
// What this block does
// - Set last-reset-by-watchdog flag after a watchdog timeout or closed-window clear reset.
// - Any access to watchdog status or timing control clears that flag.
// - Missing config resistor: flag it, use internal timebase, disable windowing.
// - Config pin grounded: report disabled, suppress timeouts, go Normal after reset.
// - Window-open flag shows clears allowed; software ignores it when resistor missing.
// - Divider select: 0 ratio one, 1 ratio 3.6; resets to 1 on power-on.
// - Channel select: 0 off, 1 reserved, 2 temperature, 3 battery, 4-7 wake inputs.
// - Channel off or Stop/Sleep leaves analog output buffer unpowered.
// - Channel select resets on any reset; divider select only on power-on.
// - Hall supply bit on/off; clears on any reset, other config bits power-on only.
// - Cyclic multiplier bit scales nonzero cyclic-sense intervals by eight.
// - Auto-zero bit turns current sense offset reduction on or off.
// - Gain select bit: 1 gives about 14.5, 0 about 30.
// - Cleared mask bit blocks its group from the pin; flags still recorded.
// - Regulator prewarning and supply undervoltage always reach the interrupt pin.
// - Voltage monitor mask gates only supply over-voltage.
// - Writing the mask register returns the interrupt source code.
// - Reading source code acknowledges; pin goes high, or high 10us then low.
// - Source code is zero when nothing is pending.
// - Codes by priority: 1 wake,2 HS,3 LS,4 bus,5 voltage,6 forced wake.
// - Several pending sources are presented one by one after each acknowledge.
// - Writing timing control returns the four watchdog status flags.
// ----------------------------------------------------------------------------
package sbc_pkg;
	// ------------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------------
	localparam logic [3:0] ADDR_TIMING_CONTROL = 4'ha;
	localparam logic [3:0] ADDR_WATCHDOG_STATUS = 4'hb;
	localparam logic [3:0] ADDR_ANALOG_MUX_CONTROL = 4'hc;
	localparam logic [3:0] ADDR_CONFIGURATION = 4'hd;
	localparam logic [3:0] ADDR_INTERRUPT_MASK = 4'he;
	localparam logic [3:0] ADDR_INTERRUPT_SOURCE = 4'hf;
	// ------------------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------------------
	localparam logic [3:0] RST_ANALOG_MUX_CONTROL = 4'h8;
	localparam logic [3:0] RST_CONFIGURATION = 4'h0;
	localparam logic [3:0] RST_INTERRUPT_MASK = 4'hf;
	localparam int MUX_DIV_BIT = 3;
	localparam int CFG_HALL_BIT = 3;
	localparam int CFG_CYC8_BIT = 2;
	localparam int CFG_AZ_BIT = 1;
	localparam int CFG_GAIN_BIT = 0;
	localparam int IMR_HS_BIT = 3;
	localparam int IMR_LS_BIT = 2;
	localparam int IMR_BUS_BIT = 1;
	localparam int IMR_VM_BIT = 0;
	// Pending source index order, highest priority first
	localparam int SRC_WAKE = 0;
	localparam int SRC_HS = 1;
	localparam int SRC_LS = 2;
	localparam int SRC_BUS = 3;
	localparam int SRC_VM_FIXED = 4;
	localparam int SRC_VM_OV = 5;
	localparam int SRC_FORCED = 6;
	localparam int SRC_N = 7;
	localparam logic [2:0] CH_OFF = 3'h0;
	// ------------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int IRQ_GAP_NS = 10000;
	localparam int IRQ_GAP_CYC = (IRQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] IRQ_GAP_CNT = 8'(IRQ_GAP_CYC);
	// ------------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [3:0] addr;
		logic [3:0] wdata;
	} sbc_req_t;
	typedef struct packed {
		logic wd_reset_event;
		logic wd_resistor_missing;
		logic wd_config_grounded;
		logic wd_window_open;
	} sbc_wd_in_t;
	typedef struct packed {
		logic watchdog_disabled_flag;
		logic internal_timebase;
		logic window_enable;
		logic normal_on_reset_exit;
	} sbc_wd_out_t;
	typedef struct packed {
		logic input_divider_select;
		logic [2:0] analog_channel_select;
		logic analog_buffer_enable;
		logic hall_supply_enable;
		logic cyclic_period_times_eight;
		logic sense_autozero_enable;
		logic sense_gain_select;
	} sbc_ana_t;
	typedef struct packed {
		logic [3:0] mux;
		logic [3:0] cfg;
		logic [3:0] interrupt_mask;
		logic last_reset_by_watchdog;
		logic [SRC_N-1:0] pend;
		logic [7:0] gap;
		logic irq_n;
		logic [3:0] rdata;
		logic rvalid;
		sbc_wd_out_t wd;
		sbc_ana_t ana;
	} sbc_state_t;
endpackage : sbc_pkg

// [sbc_regs.sv]
// Status, configuration and interrupt register bank behind the serial port
`timescale 1ns/1ps
module sbc_regs (
	// Clock and power-on reset
	input wire logic clock,
	input wire logic rst,
	// Reset Mode or external reset, one or more cycles
	input wire logic mode_reset,
	// Stop or Sleep Mode active
	input wire logic stop_or_sleep,
	// Decoded serial transfer and its answer
	input wire sbc_pkg::sbc_req_t req,
	output logic [3:0] rsp_data,
	output logic rsp_valid,
	// Watchdog status inputs and derived controls
	input wire sbc_pkg::sbc_wd_in_t wd_in,
	output sbc_pkg::sbc_wd_out_t wd_out,
	// Interrupt event pulses, index order of the package
	input wire logic [sbc_pkg::SRC_N-1:0] irq_event,
	output logic interrupt_n,
	// Analog and configuration controls
	output sbc_pkg::sbc_ana_t ana
);
	// ------------------------------------------------------------------------
	// Priority decoding
	// ------------------------------------------------------------------------
	function automatic logic [3:0] src_code(input logic [sbc_pkg::SRC_N-1:0] p);
		logic [3:0] c;
		c = 4'h0;
		if (p[sbc_pkg::SRC_WAKE]) begin
			c = 4'h1;
		end else if (p[sbc_pkg::SRC_HS]) begin
			c = 4'h2;
		end else if (p[sbc_pkg::SRC_LS]) begin
			c = 4'h3;
		end else if (p[sbc_pkg::SRC_BUS]) begin
			c = 4'h4;
		end else if (p[sbc_pkg::SRC_VM_FIXED] | p[sbc_pkg::SRC_VM_OV]) begin
			c = 4'h5;
		end else if (p[sbc_pkg::SRC_FORCED]) begin
			c = 4'h6;
		end
		return c;
	endfunction : src_code

	function automatic logic [sbc_pkg::SRC_N-1:0] code_mask(input logic [3:0] c);
		logic [sbc_pkg::SRC_N-1:0] m;
		m = '0;
		unique case (c)
			4'h1: m[sbc_pkg::SRC_WAKE] = 1'b1;
			4'h2: m[sbc_pkg::SRC_HS] = 1'b1;
			4'h3: m[sbc_pkg::SRC_LS] = 1'b1;
			4'h4: m[sbc_pkg::SRC_BUS] = 1'b1;
			4'h5: begin
				m[sbc_pkg::SRC_VM_FIXED] = 1'b1;
				m[sbc_pkg::SRC_VM_OV] = 1'b1;
			end
			4'h6: m[sbc_pkg::SRC_FORCED] = 1'b1;
			default: m = '0;
		endcase
		return m;
	endfunction : code_mask

	function automatic logic [sbc_pkg::SRC_N-1:0] gate(input logic [sbc_pkg::SRC_N-1:0] p,
			input logic [3:0] msk);
		logic [sbc_pkg::SRC_N-1:0] g;
		g = p;
		g[sbc_pkg::SRC_HS] = p[sbc_pkg::SRC_HS] & msk[sbc_pkg::IMR_HS_BIT];
		g[sbc_pkg::SRC_LS] = p[sbc_pkg::SRC_LS] & msk[sbc_pkg::IMR_LS_BIT];
		g[sbc_pkg::SRC_BUS] = p[sbc_pkg::SRC_BUS] & msk[sbc_pkg::IMR_BUS_BIT];
		g[sbc_pkg::SRC_VM_OV] = p[sbc_pkg::SRC_VM_OV] & msk[sbc_pkg::IMR_VM_BIT];
		return g; // Fixed voltage monitor source passes ungated
	endfunction : gate

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	sbc_pkg::sbc_state_t st;
	sbc_pkg::sbc_state_t next_st;
	logic [3:0] cur_code;
	logic [3:0] wd_status;
	logic ack;
	logic wd_touch;
	logic [sbc_pkg::SRC_N-1:0] pend_after;

	always_comb begin
		cur_code = src_code(st.pend);
		wd_status = {st.last_reset_by_watchdog, wd_in.wd_resistor_missing,
			wd_in.wd_config_grounded, wd_in.wd_window_open};
		ack = req.valid & ~req.write & (req.addr == sbc_pkg::ADDR_INTERRUPT_SOURCE);
		wd_touch = req.valid & ((req.addr == sbc_pkg::ADDR_TIMING_CONTROL) |
			(req.addr == sbc_pkg::ADDR_WATCHDOG_STATUS));
		pend_after = st.pend & ~(ack ? code_mask(cur_code) : '0);
		next_st = st;
		next_st.rvalid = req.valid;
		next_st.rdata = 4'h0;
		if (req.valid) begin
			if (req.addr == sbc_pkg::ADDR_TIMING_CONTROL || req.addr == sbc_pkg::ADDR_WATCHDOG_STATUS) begin
				next_st.rdata = wd_status;
			end
			if (req.addr == sbc_pkg::ADDR_INTERRUPT_MASK || req.addr == sbc_pkg::ADDR_INTERRUPT_SOURCE) begin
				next_st.rdata = cur_code;
			end
			if (req.write && req.addr == sbc_pkg::ADDR_ANALOG_MUX_CONTROL) begin
				next_st.mux = req.wdata;
			end
			if (req.write && req.addr == sbc_pkg::ADDR_CONFIGURATION) begin
				next_st.cfg = req.wdata;
			end
			if (req.write && req.addr == sbc_pkg::ADDR_INTERRUPT_MASK) begin
				next_st.interrupt_mask = req.wdata;
			end
		end
		// Set wins over the clear on the same edge
		next_st.last_reset_by_watchdog = (st.last_reset_by_watchdog & ~wd_touch) | wd_in.wd_reset_event;
		next_st.pend = pend_after | irq_event;
		if (ack && (|gate(next_st.pend, next_st.interrupt_mask))) begin
			next_st.gap = sbc_pkg::IRQ_GAP_CNT;
		end else if (st.gap != 8'h00) begin
			next_st.gap = st.gap - 8'h01;
		end else begin
			next_st.gap = 8'h00;
		end
		next_st.irq_n = (next_st.gap != 8'h00) | ~(|gate(next_st.pend, next_st.interrupt_mask));
		if (mode_reset) begin
			next_st.mux[2:0] = sbc_pkg::CH_OFF;
			next_st.cfg[sbc_pkg::CFG_HALL_BIT] = 1'b0;
		end
		next_st.wd.watchdog_disabled_flag = wd_in.wd_config_grounded;
		next_st.wd.normal_on_reset_exit = wd_in.wd_config_grounded;
		next_st.wd.internal_timebase = wd_in.wd_resistor_missing;
		next_st.wd.window_enable = ~wd_in.wd_resistor_missing & ~wd_in.wd_config_grounded;
		next_st.ana.input_divider_select = next_st.mux[sbc_pkg::MUX_DIV_BIT];
		next_st.ana.analog_channel_select = next_st.mux[2:0];
		next_st.ana.analog_buffer_enable = (next_st.mux[2:0] != sbc_pkg::CH_OFF) & ~stop_or_sleep;
		next_st.ana.hall_supply_enable = next_st.cfg[sbc_pkg::CFG_HALL_BIT];
		next_st.ana.cyclic_period_times_eight = next_st.cfg[sbc_pkg::CFG_CYC8_BIT];
		next_st.ana.sense_autozero_enable = next_st.cfg[sbc_pkg::CFG_AZ_BIT];
		next_st.ana.sense_gain_select = next_st.cfg[sbc_pkg::CFG_GAIN_BIT];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.mux <= sbc_pkg::RST_ANALOG_MUX_CONTROL;
			st.cfg <= sbc_pkg::RST_CONFIGURATION;
			st.interrupt_mask <= sbc_pkg::RST_INTERRUPT_MASK;
			st.irq_n <= 1'b1;
			st.ana.input_divider_select <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign rsp_data = st.rdata;
	assign rsp_valid = st.rvalid;
	assign wd_out = st.wd;
	assign interrupt_n = st.irq_n;
	assign ana = st.ana;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic [8:0] high_run;
	always_ff @(posedge clock) begin
		// Counts only while an enabled source waits behind a high pin
		if (rst || !st.irq_n || !(|gate(st.pend, st.interrupt_mask))) begin
			high_run <= 9'h000;
		end else if (high_run != 9'h1ff) begin
			high_run <= high_run + 9'h001;
		end
	end

	property p_wd_flag_set;
		wd_in.wd_reset_event |=> st.last_reset_by_watchdog;
	endproperty
	a_wd_flag_set: assert property (p_wd_flag_set) else $error("watchdog reset flag not set");

	property p_wd_flag_clear;
		wd_touch && !wd_in.wd_reset_event |=> !st.last_reset_by_watchdog;
	endproperty
	a_wd_flag_clear: assert property (p_wd_flag_clear) else $error("watchdog reset flag not cleared");

	property p_window_off;
		wd_in.wd_resistor_missing |=> !wd_out.window_enable && wd_out.internal_timebase;
	endproperty
	a_window_off: assert property (p_window_off) else $error("windowing not disabled");

	property p_buffer_off;
		(stop_or_sleep || next_st.mux[2:0] == sbc_pkg::CH_OFF) |=> !ana.analog_buffer_enable;
	endproperty
	a_buffer_off: assert property (p_buffer_off) else $error("analog buffer powered");

	property p_mode_reset;
		mode_reset |=> ana.analog_channel_select == sbc_pkg::CH_OFF && !ana.hall_supply_enable
			&& ana.input_divider_select == $past(st.mux[sbc_pkg::MUX_DIV_BIT]);
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode reset clears wrong fields");

	property p_imr_echo;
		req.valid && req.write && req.addr == sbc_pkg::ADDR_INTERRUPT_MASK |=> rsp_valid && rsp_data == $past(cur_code);
	endproperty
	a_imr_echo: assert property (p_imr_echo) else $error("mask write did not return source code");

	property p_timing_echo;
		req.valid && req.addr == sbc_pkg::ADDR_TIMING_CONTROL |=> rsp_data == $past(wd_status);
	endproperty
	a_timing_echo: assert property (p_timing_echo) else $error("timing write did not return status");

	property p_gap;
		ack && (|gate(next_st.pend, next_st.interrupt_mask)) |=> interrupt_n [*8] ##192 interrupt_n ##1 !interrupt_n;
	endproperty
	a_gap: assert property (p_gap) else $error("interrupt gap not 200 cycles");

	property p_gap_bound;
		high_run <= 9'(sbc_pkg::IRQ_GAP_CYC) || !(|gate(st.pend, st.interrupt_mask));
	endproperty
	a_gap_bound: assert property (p_gap_bound) else $error("interrupt pin held high too long");

	property p_fixed_irq;
		irq_event[sbc_pkg::SRC_VM_FIXED] && st.gap == 8'h00 |=> !interrupt_n;
	endproperty
	a_fixed_irq: assert property (p_fixed_irq) else $error("unmaskable source did not interrupt");

	property p_masked_hs;
		st.interrupt_mask == 4'h_0 && st.pend[sbc_pkg::SRC_VM_FIXED] == 1'b0 && st.pend[sbc_pkg::SRC_WAKE] == 1'b0
			&& st.pend[sbc_pkg::SRC_FORCED] == 1'b0 && irq_event == 7'(1 << sbc_pkg::SRC_HS)
			&& req.valid == 1'b0 && mode_reset == 1'b0 |=> st.pend[sbc_pkg::SRC_HS] && interrupt_n;
	endproperty
	a_masked_hs: assert property (p_masked_hs) else $error("masked source reached pin or lost");

	property p_zero_code;
		st.pend == '0 |-> cur_code == 4'h0;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("nonzero code with nothing pending");

	c_ack_next: cover property (ack && |pend_after);
	c_mask_write: cover property (req.valid && req.write && req.addr == sbc_pkg::ADDR_INTERRUPT_MASK);
	c_wd_clear: cover property (st.last_reset_by_watchdog ##1 wd_touch);
	c_buffer_on: cover property (ana.analog_buffer_enable);
	c_gap_end: cover property (st.gap == 8'h01 ##1 !interrupt_n);

	// ------------------------------------------------------------------------
	// Register write, watchdog, analog buffer and interrupt checks
	// ------------------------------------------------------------------------
	property p_mux_write;
		req.valid && req.write && req.addr == sbc_pkg::ADDR_ANALOG_MUX_CONTROL && !mode_reset
			|=> {ana.input_divider_select, ana.analog_channel_select} == $past(req.wdata);
	endproperty
	a_mux_write: assert property (p_mux_write) else $error("mux write not applied");

	property p_cfg_write;
		req.valid && req.write && req.addr == sbc_pkg::ADDR_CONFIGURATION && !mode_reset
			|=> {ana.hall_supply_enable, ana.cyclic_period_times_eight, ana.sense_autozero_enable,
			ana.sense_gain_select} == $past(req.wdata);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not applied");

	property p_wd_off;
		wd_in.wd_config_grounded |=> wd_out.watchdog_disabled_flag && wd_out.normal_on_reset_exit && !wd_out.window_enable;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("grounded config pin not reported");

	property p_read_code;
		ack |=> rsp_valid && rsp_data == $past(cur_code);
	endproperty
	a_read_code: assert property (p_read_code) else $error("source read returned wrong code");

	property p_ack_wake;
		ack && cur_code == 4'h1 && !irq_event[sbc_pkg::SRC_WAKE] |=> !st.pend[sbc_pkg::SRC_WAKE];
	endproperty
	a_ack_wake: assert property (p_ack_wake) else $error("acknowledged source still pending");

	property p_idle_high;
		st.pend == '0 |-> interrupt_n;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("pin low with nothing pending");

	property p_mask_store;
		req.valid && req.write && req.addr == sbc_pkg::ADDR_INTERRUPT_MASK |=> st.interrupt_mask == $past(req.wdata);
	endproperty
	a_mask_store: assert property (p_mask_store) else $error("mask write not stored");

	property p_buffer_on;
		!stop_or_sleep && next_st.mux[2:0] != sbc_pkg::CH_OFF |=> ana.analog_buffer_enable;
	endproperty
	a_buffer_on: assert property (p_buffer_on) else $error("analog buffer not powered");

	property p_irq_cause;
		!interrupt_n |-> (|gate(st.pend, st.interrupt_mask));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("pin low without enabled source");

	property p_masked_group;
		st.interrupt_mask == 4'h0 && st.pend == '0 && !req.valid && irq_event[sbc_pkg::SRC_VM_OV]
			&& !irq_event[sbc_pkg::SRC_WAKE] && !irq_event[sbc_pkg::SRC_VM_FIXED] && !irq_event[sbc_pkg::SRC_FORCED]
			|=> interrupt_n && st.pend[sbc_pkg::SRC_VM_OV];
	endproperty
	a_masked_group: assert property (p_masked_group) else $error("masked over-voltage reached pin");

	property p_gap_wait;
		st.gap > 8'h01 |=> interrupt_n;
	endproperty
	a_gap_wait: assert property (p_gap_wait) else $error("pin low inside acknowledge gap");
endmodule : sbc_regs

// [sbc_host_model.sv]
// Microcontroller side: issues decoded serial transfers to the register bank
`timescale 1ns/1ps
module sbc_host_model (
	// Clock
	input wire logic clock,
	// Transfer request and its answer
	output sbc_pkg::sbc_req_t req,
	input wire logic [3:0] rsp_data,
	input wire logic rsp_valid
);
	initial begin
		req = '0;
	end
	// ------------------------------------------------------------------------
	// One transfer: launched off the sampling edge, answer taken one cycle on
	// ------------------------------------------------------------------------
	task automatic access(input logic wr, input logic [3:0] addr, input logic [3:0] wdata, output logic [3:0] rdata);
		int n;
		n = 0;
		@(negedge clock);
		req = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
		@(negedge clock);
		req = '0;
		while (rsp_valid !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		// Missing answer shows as unknown so the caller's compare fails
		rdata = (rsp_valid === 1'b1) ? rsp_data : 4'hx;
	endtask : access
endmodule : sbc_host_model

// [test_sbc_status_config_irq_regs.sv]
// Self-checking testbench of the status, configuration and interrupt register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module test_sbc_status_config_irq_regs;
	// ------------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------------
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic mode_reset = 1'b0;
	logic stop_or_sleep = 1'b0;
	sbc_pkg::sbc_req_t req;
	logic [3:0] rsp_data;
	logic rsp_valid;
	sbc_pkg::sbc_wd_in_t wd_in = '0;
	sbc_pkg::sbc_wd_out_t wd_out;
	logic [6:0] irq_event = '0;
	logic interrupt_n;
	sbc_pkg::sbc_ana_t ana;
	int miscompares = 0;
	int total_checks = 0;
	logic [3:0] rd;
	always #25 clock = ~clock;
	sbc_regs sbc_regs_inst (.clock(clock), .rst(rst), .mode_reset(mode_reset), .stop_or_sleep(stop_or_sleep),
		.req(req), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .wd_in(wd_in), .wd_out(wd_out),
		.irq_event(irq_event), .interrupt_n(interrupt_n), .ana(ana));
	sbc_host_model sbc_host_model_inst (.clock(clock), .req(req), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask : step
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [3:0] d);
		sbc_host_model_inst.access(wr, a, d, rd);
	endtask : xfer
	task automatic ev(input logic [6:0] m);
		@(negedge clock);
		irq_event = m;
		@(negedge clock);
		irq_event = '0;
	endtask : ev
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_reset;
		`CHK("mux", 4'h8, {ana.input_divider_select, ana.analog_channel_select})
		`CHK("cfg", 4'h0, {ana.hall_supply_enable, ana.cyclic_period_times_eight, ana.sense_autozero_enable, ana.sense_gain_select})
		`CHK("buffer", 1'b0, ana.analog_buffer_enable)
		`CHK("pin", 1'b1, interrupt_n)
		xfer(1'b0, 4'hf, 4'h0);
		`CHK("code idle", 4'h0, rd)
		$display("t_reset done");
	endtask : t_reset
	task automatic t_mux;
		for (int ch = 0; ch < 8; ch++) begin
			xfer(1'b1, 4'hc, 4'(ch));
			`CHK("channel", 3'(ch), ana.analog_channel_select)
			`CHK("divider", 1'b0, ana.input_divider_select)
			if (ch != 1)
				`CHK("buffer", (ch != 0), ana.analog_buffer_enable)
		end
		stop_or_sleep = 1'b1;
		step(2);
		`CHK("buffer stop", 1'b0, ana.analog_buffer_enable)
		stop_or_sleep = 1'b0;
		$display("t_mux done");
	endtask : t_mux
	task automatic t_cfg;
		xfer(1'b1, 4'hd, 4'hf);
		`CHK("cfg", 4'hf, {ana.hall_supply_enable, ana.cyclic_period_times_eight, ana.sense_autozero_enable, ana.sense_gain_select})
		xfer(1'b1, 4'hc, 4'hd);
		mode_reset = 1'b1;
		step(1);
		mode_reset = 1'b0;
		step(1);
		`CHK("cfg mode", 4'h7, {ana.hall_supply_enable, ana.cyclic_period_times_eight, ana.sense_autozero_enable, ana.sense_gain_select})
		`CHK("mux mode", 4'h8, {ana.input_divider_select, ana.analog_channel_select})
		$display("t_cfg done");
	endtask : t_cfg
	task automatic t_watchdog;
		wd_in = '{wd_reset_event: 1'b1, wd_resistor_missing: 1'b1, wd_config_grounded: 1'b0, wd_window_open: 1'b1};
		step(1);
		wd_in.wd_reset_event = 1'b0;
		step(2);
		`CHK("timebase", 2'b10, {wd_out.internal_timebase, wd_out.window_enable})
		xfer(1'b1, 4'ha, 4'h0);
		`CHK("status wr", 4'hd, rd)
		xfer(1'b0, 4'hb, 4'h0);
		`CHK("status rd", 4'h5, rd)
		wd_in = '{wd_reset_event: 1'b1, wd_resistor_missing: 1'b0, wd_config_grounded: 1'b1, wd_window_open: 1'b1};
		step(1);
		wd_in.wd_reset_event = 1'b0;
		step(2);
		`CHK("disabled", 2'b11, {wd_out.watchdog_disabled_flag, wd_out.normal_on_reset_exit})
		xfer(1'b0, 4'hb, 4'h0);
		`CHK("status off", 4'hb, rd)
		xfer(1'b1, 4'ha, 4'h0);
		`CHK("status cleared", 4'h3, rd)
		wd_in = '0;
		$display("t_watchdog done");
	endtask : t_watchdog
	task automatic t_irq_prio;
		ev(7'h7f);
		step(1);
		`CHK("pin low", 1'b0, interrupt_n)
		for (int k = 1; k <= 6; k++) begin
			xfer(1'b0, 4'hf, 4'h0);
			`CHK("code", 4'(k), rd)
			`CHK("pin ack", 1'b1, interrupt_n)
			step(190);
			`CHK("pin gap", 1'b1, interrupt_n)
			step(20);
			`CHK("pin again", (k == 6), interrupt_n)
		end
		xfer(1'b0, 4'hf, 4'h0);
		`CHK("code empty", 4'h0, rd)
		$display("t_irq_prio done");
	endtask : t_irq_prio
	task automatic t_irq_mask;
		xfer(1'b1, 4'he, 4'h0);
		`CHK("mask echo", 4'h0, rd)
		ev(7'h2e);
		step(3);
		`CHK("pin masked", 1'b1, interrupt_n)
		xfer(1'b1, 4'he, 4'h0);
		`CHK("mask echo", 4'h2, rd)
		for (int k = 2; k <= 5; k++) begin
			xfer(1'b0, 4'hf, 4'h0);
			`CHK("masked code", 4'(k), rd)
		end
		ev(7'h10);
		step(2);
		`CHK("pin fixed", 1'b0, interrupt_n)
		xfer(1'b0, 4'hf, 4'h0);
		`CHK("fixed code", 4'h5, rd)
		ev(7'h02);
		step(2);
		`CHK("pin hs masked", 1'b1, interrupt_n)
		xfer(1'b1, 4'he, 4'hf);
		`CHK("mask echo", 4'h2, rd)
		step(2);
		`CHK("pin unmasked", 1'b0, interrupt_n)
		xfer(1'b0, 4'hf, 4'h0);
		`CHK("pin cleared", 1'b1, interrupt_n)
		$display("t_irq_mask done");
	endtask : t_irq_mask
	// ------------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------------
	initial begin
		step(4);
		rst = 1'b0;
		step(1);
		t_reset();
		t_mux();
		t_cfg();
		t_watchdog();
		t_irq_prio();
		t_irq_mask();
		give_verdict();
	end
	initial begin
		#(30000 * 50);
		miscompares++;
		give_verdict();
	end
endmodule : test_sbc_status_config_irq_regs
